// File: rtl/mpso_top.v
// post-processing and serial output of measured values
// assumes values arrive on clk from the measurement engine
`timescale 1ns/1ps
`include "mpso_consts.vh"
module mpso_top (
  input wire clk,
  input wire srst,
  input wire meas_strobe,
  input wire [`MPSO_NSEL*18-1:0] meas_values,
  input wire [`MPSO_NSEL-1:0] meas_valid,
  input wire [`MPSO_NSEL-1:0] serial_select,
  input wire [`MPSO_NSEL-1:0] net_select,
  input wire [39:0] master_map,
  input wire [`MPSO_NCH*18-1:0] master_values,
  input wire [`MPSO_NCH-1:0] master_enable,
  input wire [`MPSO_NCH-1:0] master_set,
  input wire [`MPSO_NCH-1:0] master_undo,
  input wire [39:0] stat_map,
  input wire [3:0] stat_win_log,
  input wire stat_unbounded,
  input wire [`MPSO_NCH-1:0] stat_reset,
  input wire [21:0] reduce_n,
  input wire [2:0] reduce_enable,
  input wire [1:0] error_mode,
  input wire [10:0] hold_count,
  input wire [15:0] baud_div,
  input wire video_enable,
  input wire [15:0] video_len,
  input wire [15:0] video_sample,
  output wire video_req,
  output reg [`MPSO_NCH*18-1:0] stat_min,
  output reg [`MPSO_NCH*18-1:0] stat_max,
  output reg [`MPSO_NCH*18-1:0] stat_p2p,
  output reg net_strobe,
  output reg analog_strobe,
  output reg [`MPSO_NSEL*18-1:0] net_values,
  output reg [`MPSO_NSEL-1:0] net_mask,
  output reg busy,
  output reg overrun,
  output reg txd
);
  // 16 values, one sample each; 10 stat channels of 16-deep windows
  reg [17:0] out_val [0:15];
  reg [17:0] last_val [0:15];
  reg [10:0] hold_cnt [0:15];
  reg [17:0] offs [0:9];
  reg offs_on [0:9];
  reg [17:0] win [0:9][0:15];
  reg [14:0] fill [0:9];
  reg [3:0] wp [0:9];
  reg [21:0] red_cnt;
  reg [15:0] sel;
  reg [3:0] idx;
  reg [2:0] st;
  reg [1:0] bsel;
  reg [4:0] hcnt;
  reg [15:0] vcnt;
  reg [7:0] pbyte;
  reg pvalid;
  reg first;
  reg [17:0] cur;
  reg [15:0] bcnt;
  reg [3:0] bitn;
  reg [9:0] sh;
  reg tx_on;
  reg net_pend;
  wire f_ready;
  wire [7:0] f_data;
  wire f_valid;
  wire f_take = tx_on ? 1'b0 : f_valid;
  integer i;
  integer k;
  localparam S_IDLE = 3'h0;
  localparam S_VHDR = 3'h1;
  localparam S_VDAT = 3'h2;
  localparam S_VEND = 3'h3;
  localparam S_VAL = 3'h4;
  function [17:0] pick;
    input [`MPSO_NSEL*18-1:0] bus;
    input [3:0] n;
    begin
      pick = bus[n*18 +: 18];
    end
  endfunction
  // 18-bit value to tagged 6-bit bytes
  function [7:0] vbyte;
    input [17:0] v;
    input [1:0] b;
    input f;
    begin
      case (b)
        2'h0: vbyte = {`MPSO_TAG_L, v[5:0]};
        2'h1: vbyte = {`MPSO_TAG_M, v[11:6]};
        default: vbyte = {(f ? `MPSO_TAG_H1 : `MPSO_TAG_H), v[17:12]};
      endcase
    end
  endfunction
  wire [63:0] vhdr = {`MPSO_VSTART};
  wire [31:0] vsize = {15'h0000, video_len, 1'b0};
  // odd count: low byte goes now, source steps to the next sample
  wire vbyte_lo_free = vcnt[0];
  assign video_req = (st == S_VDAT) && (!pvalid || f_ready) && vbyte_lo_free;
  wire [31:0] vend_w = `MPSO_VEND;
  // one in n passes when reduction enabled
  wire red_pass = (red_cnt == 22'h000000);
  wire ser_go = meas_strobe && (red_pass || !reduce_enable[0]);
  always @(posedge clk) begin
    if (srst) begin
      red_cnt <= 22'h000000;
      net_pend <= 1'b0;
      net_strobe <= 1'b0;
      analog_strobe <= 1'b0;
      net_values <= {(`MPSO_NSEL*18){1'b0}};
      net_mask <= {`MPSO_NSEL{1'b0}};
      for (i = 0; i < 16; i = i + 1) begin
        out_val[i] <= 18'h00000;
        last_val[i] <= 18'h00000;
        hold_cnt[i] <= 11'h000;
      end
      for (i = 0; i < 10; i = i + 1) begin
        offs[i] <= 18'h00000;
        offs_on[i] <= 1'b0;
        fill[i] <= 15'h0000;
        wp[i] <= 4'h0;
      end
      stat_min <= {(`MPSO_NCH*18){1'b0}};
      stat_max <= {(`MPSO_NCH*18){1'b0}};
      stat_p2p <= {(`MPSO_NCH*18){1'b0}};
    end else begin
      net_strobe <= 1'b0;
      analog_strobe <= 1'b0;
      // offset capture; set wins, undo clears
      for (i = 0; i < 10; i = i + 1) begin
        if (master_enable[i] && master_set[i]) begin
          offs[i] <= pick(meas_values, master_map[i*4 +: 4])
            - master_values[i*18 +: 18];
          offs_on[i] <= 1'b1;
        end else if (master_undo[i])
          offs_on[i] <= 1'b0;
      end
      if (meas_strobe) begin
        red_cnt <= (red_cnt + 22'h000001 >= reduce_n) ? 22'h000000
          : red_cnt + 22'h000001;
        for (i = 0; i < 16; i = i + 1) begin
          if (meas_valid[i]) begin
            out_val[i] <= pick(meas_values, i[3:0]);
            last_val[i] <= pick(meas_values, i[3:0]);
            hold_cnt[i] <= 11'h000;
          end else begin
            case (error_mode)
              `MPSO_MODE_HOLDINF: out_val[i] <= last_val[i];
              `MPSO_MODE_HOLDCNT: begin
                if (hold_count == 11'h000 || hold_cnt[i] < hold_count) begin
                  out_val[i] <= last_val[i];
                  hold_cnt[i] <= hold_cnt[i] + 11'h001;
                end else
                  out_val[i] <= `MPSO_ERR_INCALC;
              end
              default: out_val[i] <= `MPSO_ERR_INCALC;
            endcase
          end
          for (k = 0; k < 10; k = k + 1)
            // hold modes must repeat the mastered value, not the raw one
            if (offs_on[k] && master_map[k*4 +: 4] == i[3:0]
                && meas_valid[i]) begin
              out_val[i] <= pick(meas_values, i[3:0]) - offs[k];
              last_val[i] <= pick(meas_values, i[3:0]) - offs[k];
            end
        end
        for (k = 0; k < 10; k = k + 1) begin
          win[k][wp[k]] <= pick(meas_values, stat_map[k*4 +: 4]);
          wp[k] <= wp[k] + 4'h1;
          if (stat_reset[k])
            fill[k] <= 15'h0001;
          else if (fill[k] != 15'h7FFF)
            fill[k] <= fill[k] + 15'h0001;
        end
      end else begin
        for (k = 0; k < 10; k = k + 1)
          if (stat_reset[k])
            fill[k] <= 15'h0000;
      end
      // extremes over window; unbounded keeps running extremes
      for (k = 0; k < 10; k = k + 1) begin : stat
        reg [17:0] mn;
        reg [17:0] mx;
        reg [17:0] v;
        reg [15:0] wl;
        mn = 18'h3FFFF;
        mx = 18'h00000;
        wl = 16'h0001 << stat_win_log;
        for (i = 0; i < 16; i = i + 1) begin
          v = win[k][wp[k] - 4'h1 - i[3:0]];
          if (i < fill[k] && (i < wl || stat_unbounded)) begin
            if (v < mn) mn = v;
            if (v > mx) mx = v;
          end
        end
        if (stat_unbounded && fill[k] > 15'h0010) begin
          if (stat_min[k*18 +: 18] < mn) mn = stat_min[k*18 +: 18];
          if (stat_max[k*18 +: 18] > mx) mx = stat_max[k*18 +: 18];
        end
        if (fill[k] != 15'h0000) begin
          stat_min[k*18 +: 18] <= mn;
          stat_max[k*18 +: 18] <= mx;
          stat_p2p[k*18 +: 18] <= mx - mn;
        end
      end
      // network path independent of serial selection
      // one cycle late, so net_values carries this cycle's out_val
      net_pend <= meas_strobe && (red_pass || !reduce_enable[2]);
      if (net_pend) begin
        net_strobe <= 1'b1;
        net_mask <= net_select;
        for (i = 0; i < 16; i = i + 1)
          net_values[i*18 +: 18] <= out_val[i];
      end
      if (meas_strobe && (red_pass || !reduce_enable[1]))
        analog_strobe <= 1'b1;
    end
  end
  // frame builder, video first then values by index
  always @(posedge clk) begin
    if (srst) begin
      st <= S_IDLE;
      sel <= 16'h0000;
      idx <= 4'h0;
      bsel <= 2'h0;
      hcnt <= 5'h00;
      vcnt <= 16'h0000;
      pvalid <= 1'b0;
      pbyte <= 8'h00;
      first <= 1'b0;
      cur <= 18'h00000;
      busy <= 1'b0;
      overrun <= 1'b0;
    end else begin
      if (pvalid && f_ready)
        pvalid <= 1'b0;
      // busy lags the return to idle by one cycle
      if (ser_go && st != S_IDLE)
        overrun <= 1'b1;
      else if (ser_go)
        overrun <= 1'b0;
      case (st)
        S_IDLE: begin
          if (ser_go) begin
            busy <= 1'b1;
            sel <= serial_select;
            idx <= 4'h0;
            first <= 1'b1;
            hcnt <= 5'h00;
            st <= video_enable ? S_VHDR : S_VAL;
          end else
            busy <= 1'b0;
        end
        S_VHDR: if (!pvalid || f_ready) begin
          pvalid <= 1'b1;
          pbyte <= (hcnt < 5'h08) ? vhdr[63 - hcnt*8 -: 8]
            : vsize[31 - (hcnt - 5'h08)*8 -: 8];
          hcnt <= hcnt + 5'h01;
          if (hcnt == 5'h0B) begin
            st <= S_VDAT;
            vcnt <= 16'h0000;
          end
        end
        S_VDAT: if (!pvalid || f_ready) begin
          if (vcnt == {video_len[14:0], 1'b0}) begin
            st <= S_VEND;
            hcnt <= 5'h00;
          end else begin
            pvalid <= 1'b1;
            pbyte <= vcnt[0] ? video_sample[7:0] : video_sample[15:8];
            vcnt <= vcnt + 16'h0001;
          end
        end
        S_VEND: if (!pvalid || f_ready) begin
          pvalid <= 1'b1;
          pbyte <= vend_w[31 - hcnt[1:0]*8 -: 8];
          hcnt <= hcnt + 5'h01;
          if (hcnt == 5'h03)
            st <= S_VAL;
        end
        S_VAL: if (!pvalid || f_ready) begin
          if (sel == 16'h0000)
            st <= S_IDLE;
          else if (!sel[idx])
            idx <= idx + 4'h1;
          else begin
            pvalid <= 1'b1;
            pbyte <= vbyte(out_val[idx], bsel, first);
            if (bsel == 2'h2) begin
              bsel <= 2'h0;
              first <= 1'b0;
              sel[idx] <= 1'b0;
            end else
              bsel <= bsel + 2'h1;
          end
        end
        default: st <= S_IDLE;
      endcase
    end
  end
  mpso_fifo #(.WIDTH(8), .DEPTH(8), .AW(3)) u_fifo (
    .clk(clk),
    .srst(srst),
    .in_data(pbyte),
    .in_valid(pvalid),
    .in_ready(f_ready),
    .out_data(f_data),
    .out_valid(f_valid),
    .out_ready(f_take)
  );
  // 8N1 shifter; divider below 25 (faster than the 4000 kBaud maximum) falls back to the 921600 Baud default
  wire [15:0] div = (baud_div < `MPSO_DIV_MIN) ? `MPSO_DIV_DEF : baud_div;
  always @(posedge clk) begin
    if (srst) begin
      tx_on <= 1'b0;
      txd <= 1'b1;
      sh <= 10'h3FF;
      bcnt <= 16'h0000;
      bitn <= 4'h0;
    end else if (!tx_on) begin
      txd <= 1'b1;
      if (f_valid) begin
        tx_on <= 1'b1;
        sh <= {1'b1, f_data, 1'b0};
        bcnt <= 16'h0000;
        bitn <= 4'h0;
      end
    end else begin
      txd <= sh[0];
      if (bcnt == div - 16'h0001) begin
        bcnt <= 16'h0000;
        sh <= {1'b1, sh[9:1]};
        if (bitn == 4'h9)
          tx_on <= 1'b0;
        else
          bitn <= bitn + 4'h1;
      end else
        bcnt <= bcnt + 16'h0001;
    end
  end
endmodule // mpso_top

// File: rtl/mpso_consts.vh
// constants for the measurement post-processing and serial output block
// assumes one 100 MHz clock and a synchronous active-high reset
`ifndef MPSO_CONSTS_VH
`define MPSO_CONSTS_VH
`define MPSO_NCH 10
`define MPSO_NSEL 16
`define MPSO_VW 18
`define MPSO_WIN_LOG_MIN 1
`define MPSO_WIN_LOG_MAX 14
`define MPSO_RED_MAX 22'h2DC6C0
`define MPSO_HOLD_MAX 11'h400
`define MPSO_ERR_BASE 18'h3FFB8
`define MPSO_ERR_INCALC 18'h3FFBF
`define MPSO_MODE_ERR 2'h0
`define MPSO_MODE_HOLDINF 2'h1
`define MPSO_MODE_HOLDCNT 2'h2
`define MPSO_CLK_KHZ 100000
`define MPSO_BAUD_DEF_HZ 921600
`define MPSO_BAUD_MAX_HZ 4000000
`define MPSO_DIV_DEF 16'h006C
`define MPSO_DIV_MIN 16'h0019
`define MPSO_VSTART 64'hFFFF00FFFF000000
`define MPSO_VEND 32'hFEFE0000
`define MPSO_TAG_L 2'h0
`define MPSO_TAG_M 2'h1
`define MPSO_TAG_H1 2'h2
`define MPSO_TAG_H 2'h3
`endif

// File: rtl/mpso_fifo.v
// byte fifo between frame builder and uart
// assumes both sides on clk
`timescale 1ns/1ps
module mpso_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  input wire clk,
  input wire srst,
  input wire [WIDTH-1:0] in_data,
  input wire in_valid,
  output wire in_ready,
  output wire [WIDTH-1:0] out_data,
  output wire out_valid,
  input wire out_ready
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0] wp;
  reg [AW:0] rp;
  wire full = (wp[AW] != rp[AW]) && (wp[AW-1:0] == rp[AW-1:0]);
  wire empty = (wp == rp);
  assign in_ready = !full;
  assign out_valid = !empty;
  assign out_data = mem[rp[AW-1:0]];
  always @(posedge clk) begin
    if (srst) begin
      wp <= {(AW+1){1'b0}};
      rp <= {(AW+1){1'b0}};
    end else begin
      if (in_valid && !full) begin
        mem[wp[AW-1:0]] <= in_data;
        wp <= wp + 1'b1;
      end
      if (out_ready && !empty)
        rp <= rp + 1'b1;
    end
  end
endmodule // mpso_fifo

// File: testbench/mpso_top_properties.sv
// port assertions for the post-processing and serial output block
// assumes clk and srst of the top, baud_div of 25 or more
`timescale 1ns/1ps
`include "mpso_consts.vh"
module mpso_props (
  input wire clk,
  input wire srst,
  input wire meas_strobe,
  input wire [`MPSO_NSEL-1:0] meas_valid,
  input wire [2:0] reduce_enable,
  input wire [1:0] error_mode,
  input wire [`MPSO_NCH*18-1:0] stat_min,
  input wire [`MPSO_NCH*18-1:0] stat_max,
  input wire [`MPSO_NCH*18-1:0] stat_p2p,
  input wire net_strobe,
  input wire analog_strobe,
  input wire [`MPSO_NSEL*18-1:0] net_values,
  input wire txd
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  property p_net_cause;
    net_strobe |-> $past(meas_strobe, 2);
  endproperty
  a_net_cause: assert property (p_net_cause)
    else $error("network pulse without a measurement");
  property p_net_all;
    meas_strobe && !reduce_enable[2] |-> ##2 net_strobe;
  endproperty
  a_net_all: assert property (p_net_all)
    else $error("unreduced network output missing");
  property p_ana_all;
    meas_strobe && !reduce_enable[1] |=> analog_strobe;
  endproperty
  a_ana_all: assert property (p_ana_all)
    else $error("unreduced analog output missing");
  property p_p2p;
    stat_p2p[17:0] == stat_max[17:0] - stat_min[17:0];
  endproperty
  a_p2p: assert property (p_p2p)
    else $error("peak-to-peak not max minus min");
  property p_order;
    stat_min[17:0] <= stat_max[17:0];
  endproperty
  a_order: assert property (p_order)
    else $error("window minimum above maximum");
  property p_start;
    $fell(txd) |-> (!txd) [*8];
  endproperty
  a_start: assert property (p_start)
    else $error("start bit too short");
  property p_err;
    meas_strobe && error_mode == `MPSO_MODE_ERR && !meas_valid[0]
      && !reduce_enable[2] |-> ##2 net_values[17:0] == `MPSO_ERR_INCALC;
  endproperty
  a_err: assert property (p_err)
    else $error("error code missing for invalid value");
  property p_hold;
    meas_strobe && error_mode == `MPSO_MODE_HOLDINF && !meas_valid[0]
      && !reduce_enable[2] |-> ##2 $stable(net_values[17:0]);
  endproperty
  a_hold: assert property (p_hold)
    else $error("held value changed");
endmodule // mpso_props

bind mpso_top mpso_props mpso_props_inst (.clk, .srst, .meas_strobe,
  .meas_valid, .reduce_enable, .error_mode, .stat_min, .stat_max,
  .stat_p2p, .net_strobe, .analog_strobe, .net_values, .txd);

// File: testbench/mpso_rx_model.sv
// serial receiver standing in for the host
// assumes DIV clocks per bit, same as the sender
`timescale 1ns/1ps
module mpso_rx_model #(
  parameter DIV = 25
) (
  input wire clk,
  input wire rxd
);
  logic [7:0] q[$];
  logic [7:0] b;
  int ferr = 0;
  // code to micrometres for a range given in micrometres
  function automatic int to_um(input int code, input int range_um);
    return (code - 98232) * range_um / 65536;
  endfunction
  initial forever begin
    @(negedge rxd);
    repeat (DIV / 2) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      repeat (DIV) @(posedge clk);
      b[i] = rxd;
    end
    repeat (DIV) @(posedge clk);
    // bad stop bit drops the byte
    if (rxd)
      q.push_back(b);
    else
      ferr++;
  end
endmodule // mpso_rx_model

// File: testbench/mpso_top_tb.sv
// self-checking bench for the post-processing and serial output block
// assumes design files and receiver model compiled first
`timescale 1ns/1ps
`include "mpso_consts.vh"
module mpso_top_tb;
  reg clk = 0, srst = 1, meas_strobe = 0, stat_unbounded = 0;
  reg [`MPSO_NSEL*18-1:0] meas_values = 0;
  reg [`MPSO_NSEL-1:0] meas_valid = 0, serial_select = 0, net_select = 0;
  reg [39:0] master_map = 0, stat_map = 0;
  reg [`MPSO_NCH*18-1:0] master_values = 0;
  reg [`MPSO_NCH-1:0] master_enable = 0, master_set = 0, master_undo = 0;
  reg [`MPSO_NCH-1:0] stat_reset = 0;
  reg [3:0] stat_win_log = 4'h1;
  reg [21:0] reduce_n = 22'h000001;
  reg [2:0] reduce_enable = 0;
  reg [1:0] error_mode = 0;
  reg [10:0] hold_count = 0;
  reg [15:0] baud_div = 16'h0019;
  reg video_enable = 0;
  reg [15:0] video_len = 0, video_sample = 0;
  wire [`MPSO_NCH*18-1:0] stat_min, stat_max, stat_p2p;
  wire [`MPSO_NSEL*18-1:0] net_values;
  wire [`MPSO_NSEL-1:0] net_mask;
  wire net_strobe, analog_strobe, busy, overrun, txd, video_req;
  int miscompares = 0, num_checks = 0, n_net = 0, n_ana = 0, n_vreq = 0;
  initial forever #5 clk = ~clk;
  mpso_top mpso_top_inst (.clk, .srst, .meas_strobe, .meas_values,
    .meas_valid, .serial_select, .net_select, .master_map, .master_values,
    .master_enable, .master_set, .master_undo, .stat_map, .stat_win_log,
    .stat_unbounded, .stat_reset, .reduce_n, .reduce_enable, .error_mode,
    .hold_count, .baud_div, .video_enable, .video_len,
    .video_sample, .video_req, .stat_min, .stat_max,
    .stat_p2p, .net_strobe, .analog_strobe, .net_values, .net_mask,
    .busy, .overrun, .txd);
  mpso_rx_model #(.DIV(25)) mpso_rx_model_inst (.clk(clk), .rxd(txd));
  always @(posedge clk) begin
    if (net_strobe)
      n_net++;
    if (analog_strobe)
      n_ana++;
    if (video_req)
      n_vreq++;
  end
  task chk(input [17:0] got, input [17:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task strobe(input [17:0] v, input [15:0] vld);
    @(negedge clk);
    meas_values[17:0] = v;
    meas_valid = vld;
    meas_strobe = 1;
    @(negedge clk);
    meas_strobe = 0;
    repeat (3) @(negedge clk);
  endtask
  task pulse(input bit u);
    @(negedge clk);
    master_set = u ? 0 : 1;
    master_undo = u ? 1 : 0;
    @(negedge clk);
    master_set = 0;
    master_undo = 0;
  endtask
  task t_serial;
    serial_select = 16'h0005;
    meas_values[53:36] = 18'h2ABCD;
    strobe(18'h15A3C, 16'hFFFF);
    strobe(18'h15A3C, 16'hFFFF);
    chk(busy, 1);
    chk(overrun, 1);
    for (int i = 0; i < 3000 && mpso_rx_model_inst.q.size() < 6; i++)
      @(negedge clk);
    chk(busy, 0);
    chk(mpso_rx_model_inst.q.size(), 6);
    chk(mpso_rx_model_inst.q[0], {2'h0, 6'h3C});
    chk(mpso_rx_model_inst.q[1], {2'h1, 6'h28});
    chk(mpso_rx_model_inst.q[2], {2'h2, 6'h15});
    chk(mpso_rx_model_inst.q[3], {2'h0, 6'h0D});
    chk(mpso_rx_model_inst.q[4], {2'h1, 6'h2F});
    chk(mpso_rx_model_inst.q[5], {2'h3, 6'h2A});
    chk(mpso_rx_model_inst.ferr, 0);
    serial_select = 0;
  endtask
  task t_video;
    int n0;
    logic [159:0] vexp;
    logic [17:0] code;
    n0 = mpso_rx_model_inst.q.size();
    vexp = {`MPSO_VSTART, 32'h00000004, 32'hA55AA55A, `MPSO_VEND};
    n_vreq = 0;
    video_enable = 1;
    video_len = 16'h0002;
    video_sample = 16'hA55A;
    serial_select = 16'h0001;
    strobe(18'h27FB8, 16'hFFFF);
    chk(overrun, 0);
    for (int i = 0; i < 8000 && mpso_rx_model_inst.q.size() < n0 + 23; i++)
      @(negedge clk);
    chk(mpso_rx_model_inst.q.size(), n0 + 23);
    for (int j = 0; j < 20; j++)
      chk(mpso_rx_model_inst.q[n0 + j], vexp[159 - 8 * j -: 8]);
    code = {mpso_rx_model_inst.q[n0 + 22][5:0],
      mpso_rx_model_inst.q[n0 + 21][5:0], mpso_rx_model_inst.q[n0 + 20][5:0]};
    chk(code, 18'h27FB8);
    chk(mpso_rx_model_inst.q[n0 + 22][7:6], 2'h2);
    chk(mpso_rx_model_inst.to_um(code, 1000), 18'd1000);
    chk(n_vreq, 2);
    video_enable = 0;
    serial_select = 0;
  endtask
  task t_master;
    master_enable = 10'h001;
    master_values[17:0] = 18'h00100;
    net_select = 16'h00F0;
    strobe(18'h01000, 16'hFFFF);
    chk(net_mask, 16'h00F0);
    pulse(0);
    strobe(18'h01234, 16'hFFFF);
    chk(net_values[17:0], 18'h00334);
    pulse(0);
    strobe(18'h01300, 16'hFFFF);
    chk(net_values[17:0], 18'h001CC);
    pulse(1);
    strobe(18'h01300, 16'hFFFF);
    chk(net_values[17:0], 18'h01300);
    master_enable = 0;
  endtask
  task t_reduce;
    reduce_n = 22'h000003;
    reduce_enable = 3'h5;
    n_net = 0;
    n_ana = 0;
    repeat (6) strobe(18'h00010, 16'hFFFF);
    chk(n_net, 2);
    chk(n_ana, 6);
    reduce_n = 22'h000001;
    reduce_enable = 0;
  endtask
  task t_error;
    strobe(18'h00777, 16'h0000);
    chk(net_values[17:0], `MPSO_ERR_INCALC);
    error_mode = `MPSO_MODE_HOLDCNT;
    hold_count = 11'h002;
    strobe(18'h00777, 16'hFFFF);
    repeat (2) strobe(18'h00000, 16'h0000);
    chk(net_values[17:0], 18'h00777);
    strobe(18'h00000, 16'h0000);
    chk(net_values[17:0], `MPSO_ERR_INCALC);
    hold_count = 0;
    strobe(18'h00666, 16'hFFFF);
    repeat (4) strobe(18'h00000, 16'h0000);
    chk(net_values[17:0], 18'h00666);
    error_mode = `MPSO_MODE_HOLDINF;
    strobe(18'h00555, 16'hFFFF);
    repeat (4) strobe(18'h00000, 16'h0000);
    chk(net_values[17:0], 18'h00555);
    error_mode = `MPSO_MODE_ERR;
  endtask
  task t_stats;
    @(negedge clk);
    stat_reset = 10'h3FF;
    @(negedge clk);
    stat_reset = 0;
    strobe(18'h00005, 16'hFFFF);
    strobe(18'h00009, 16'hFFFF);
    strobe(18'h00007, 16'hFFFF);
    chk(stat_min[17:0], 18'h00007);
    chk(stat_max[17:0], 18'h00009);
    chk(stat_p2p[17:0], 18'h00002);
    @(negedge clk);
    stat_reset = 10'h001;
    @(negedge clk);
    stat_reset = 0;
    stat_unbounded = 1;
    strobe(18'h00004, 16'hFFFF);
    chk(stat_max[17:0], 18'h00004);
    strobe(18'h00008, 16'hFFFF);
    strobe(18'h00002, 16'hFFFF);
    strobe(18'h00006, 16'hFFFF);
    chk(stat_max[17:0], 18'h00008);
  endtask
  task end_sim;
    $display("checks=%0d miscompares=%0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    #200000;
    miscompares++;
    end_sim;
  end
  initial begin
    repeat (3) @(negedge clk);
    srst = 0;
    t_serial;
    t_video;
    t_master;
    t_reduce;
    t_error;
    t_stats;
    end_sim;
  end
endmodule // mpso_top_tb
